// [core/rcpp_pin_port.v]
// Pin-level port, carrier and hang-up logic of the remote-control core
//
// Operation
// RQ1: Both key-return ports are 4-bit pulled-up inputs after reset.
// RQ2: Any low key-return bit releases standby.
// RQ3: Key-source ports are 4-bit open-drain, pulled low during and after reset.
// RQ4: Bidirectional port bits have own direction; inputs after reset.
// RQ5: Input bits of bidirectional port enable pull-up per program setting.
// RQ6: Infrared output is active high, low in reset until carrier drives.
// RQ7: While reset pin is low, CPU held in reset, oscillator halted; code holds both while rst_i is high.
// RQ8: Hang-up output pulls low on watchdog, stack fault or low voltage.
// RQ9: Hang-up output floats at reset unless low voltage is detected.
// RQ10: Test mode entered through interrupt pin pulls hang-up output low.
// RQ11: Hang-up output pulls low whenever stack pointer is six or more.
// RQ12: Interrupt and key-return inputs are synchronised before use.
`timescale 1ns/1ps
`include "rcpp_defines.vh"
module rcpp_pin_port (
	input  wire       core_clk_i,
	input  wire       rst_i,
	input  wire [3:0] key_return_port_a_i,
	input  wire [3:0] key_return_port_b_i,
	output wire [3:0] key_return_port_a_o,
	output wire [3:0] key_return_port_b_o,
	output wire [3:0] key_return_pullup_o,
	input  wire       standby_i,
	output wire       standby_release_o,
	input  wire [3:0] key_source_c_wr_i,
	input  wire [3:0] key_source_d_wr_i,
	input  wire       key_source_we_i,
	output wire [3:0] key_source_port_c_oe_o,
	output wire [3:0] key_source_port_c_o,
	output wire [3:0] key_source_port_d_oe_o,
	output wire [3:0] key_source_port_d_o,
	input  wire [3:0] bidir_dir_wr_i,
	input  wire [3:0] bidir_pull_wr_i,
	input  wire [3:0] bidir_data_wr_i,
	input  wire       bidir_cfg_we_i,
	input  wire       bidir_data_we_i,
	input  wire [3:0] bidir_port_e_i,
	output wire [3:0] bidir_port_e_o,
	output wire [3:0] bidir_port_e_oe_o,
	output wire [3:0] bidir_pullup_o,
	output wire [3:0] bidir_port_e_rd_o,
	input  wire       carrier_i,
	input  wire       carrier_en_i,
	output wire       ir_carrier_out_o,
	input  wire       ext_int_i,
	output wire       ext_int_o,
	input  wire       test_mode_int_i,
	input  wire       wdt_overflow_i,
	input  wire [3:0] stack_ptr_i,
	input  wire       low_voltage_i,
	output wire       cpu_rst_o,
	output wire       osc_run_o,
	output wire       hangup_alarm_n_o,
	output wire       hangup_alarm_n_oe_o
);
	reg  [3:0] key_src_c;
	reg  [3:0] key_src_d;
	reg  [3:0] bidir_dir;
	reg  [3:0] bidir_pull;
	reg  [3:0] bidir_data;
	reg        ir_out;
	reg        wdt_latch;
	reg        hang_drive;
	reg        rel;
	reg        next_hang;
	wire [3:0] ka_s;
	wire [3:0] kb_s;
	wire [1:0] misc_s;
	wire       key_any_low;
	wire       hang_by_wdt;
	wire       hang_by_stack;
	wire       hang_by_test;
	wire       hang_by_lv;

	// Idle level of key-return pins is high (pull-ups)
	rcpp_sync2 #(.W(8)) u_key_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    ({key_return_port_b_i, key_return_port_a_i}),
		.rst_val_i  (`RCPP_KEY_IDLE),
		.sync_o     ({kb_s, ka_s})
	); // [RQ12]

	// Test mode and interrupt pins idle low
	rcpp_sync2 #(.W(2)) u_misc_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    ({test_mode_int_i, ext_int_i}),
		.rst_val_i  (`RCPP_INT_IDLE),
		.sync_o     (misc_s)
	); // [RQ12]

	// Inputs only, pull-ups always on
	assign key_return_port_a_o = ka_s; // [RQ1]
	assign key_return_port_b_o = kb_s; // [RQ1]
	assign key_return_pullup_o = `RCPP_PULL_ON; // [RQ1]
	assign ext_int_o           = misc_s[0];

	// A closed key in a driven column pulls its row low
	assign key_any_low = ~(&{ka_s, kb_s}); // [RQ2]

	// Registered release keeps the wake strobe glitch free
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			rel <= 1'b0;
		end else begin
			rel <= standby_i & key_any_low; // [RQ2]
		end
	end
	assign standby_release_o = rel;

	// Port latches are written by strobes, no bus
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			key_src_c <= `RCPP_KEY_SRC_RST; // [RQ3]
			key_src_d <= `RCPP_KEY_SRC_RST; // [RQ3]
		end else if (key_source_we_i) begin
			key_src_c <= key_source_c_wr_i;
			key_src_d <= key_source_d_wr_i;
		end
	end

	// Config and data strobes are independent
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			bidir_dir  <= `RCPP_DIR_RST; // [RQ4]
			bidir_pull <= `RCPP_PULL_RST;
			bidir_data <= `RCPP_DATA_RST;
		end else begin
			if (bidir_cfg_we_i) begin
				bidir_dir  <= bidir_dir_wr_i; // [RQ4]
				bidir_pull <= bidir_pull_wr_i; // [RQ5]
			end
			if (bidir_data_we_i) begin
				bidir_data <= bidir_data_wr_i;
			end
		end
	end

	// One slice per pin bit of the driven ports
	genvar b;
	generate
		for (b = 0; b < `RCPP_PORT_W; b = b + 1) begin : g_pin
			// Open drain: a zero bit drives, a one bit floats
			assign key_source_port_c_o[b]    = 1'b0;
			assign key_source_port_c_oe_o[b] = ~key_src_c[b]; // [RQ3]
			assign key_source_port_d_o[b]    = 1'b0;
			assign key_source_port_d_oe_o[b] = ~key_src_d[b]; // [RQ3]

			assign bidir_port_e_o[b]    = bidir_data[b];
			assign bidir_port_e_oe_o[b] = bidir_dir[b]; // [RQ4]
			// Pull-up only matters on bits set as input
			assign bidir_pullup_o[b] = bidir_pull[b] &
				~bidir_dir[b]; // [RQ5]
			// Output bits read back the latch, not the pin
			assign bidir_port_e_rd_o[b] = bidir_dir[b] ?
				bidir_data[b] : bidir_port_e_i[b];
		end
	endgenerate

	// Registered so gate skew cannot glitch the emitter
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			ir_out <= `RCPP_IR_RST; // [RQ6]
		end else begin
			ir_out <= carrier_en_i & carrier_i; // [RQ6]
		end
	end
	assign ir_carrier_out_o = ir_out;

	// Reset pin is taken synchronous here, so hold is combinational
	assign cpu_rst_o = rst_i; // [RQ7]
	assign osc_run_o = rst_i ? 1'b0 : `RCPP_OSC_RUN; // [RQ7]

	// Watchdog overflow is a pulse; hold it until reset clears it
	// Reset wins over set; only reset clears the latch
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			wdt_latch <= 1'b0;
		end else if (wdt_overflow_i) begin
			wdt_latch <= 1'b1; // [RQ8]
		end
	end

	// Causes kept apart so a stuck alarm is easy to trace
	assign hang_by_wdt   = wdt_overflow_i | wdt_latch; // [RQ8]
	assign hang_by_stack = (stack_ptr_i >= `RCPP_SP_ALARM); // [RQ11]
	assign hang_by_test  = misc_s[1]; // [RQ10]
	assign hang_by_lv    = low_voltage_i; // [RQ8]

	// Any cause drives the alarm low
	always @* begin
		next_hang = 1'b0;
		if (hang_by_wdt) begin
			next_hang = 1'b1;
		end
		if (hang_by_stack) begin
			next_hang = 1'b1;
		end
		if (hang_by_test) begin
			next_hang = 1'b1;
		end
		if (hang_by_lv) begin
			next_hang = 1'b1;
		end
	end

	// One flop of delay; reset lets the pin float
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			hang_drive <= `RCPP_HANG_RST; // [RQ9]
		end else begin
			hang_drive <= next_hang;
		end
	end

	// Low voltage bypasses reset so the pin keeps the part held
	assign hangup_alarm_n_o    = 1'b0;
	assign hangup_alarm_n_oe_o = hang_drive | hang_by_lv; // [RQ9]
endmodule

// [core/rcpp_defines.vh]
// Constants for the remote-control pin port logic
`ifndef RCPP_DEFINES_VH
`define RCPP_DEFINES_VH
`define RCPP_PORT_W        4
`define RCPP_SP_W          4
`define RCPP_SP_ALARM      4'h6
`define RCPP_SP_RESET      4'h7
`define RCPP_KEY_SRC_RST   4'h0
`define RCPP_DIR_RST       4'h0
`define RCPP_PULL_RST      4'h0
`define RCPP_OSC_RUN       1'b1
`define RCPP_KEY_IDLE      8'hFF
`define RCPP_INT_IDLE      2'h0
`define RCPP_PULL_ON       4'hF
`define RCPP_DATA_RST      4'h0
`define RCPP_IR_RST        1'b0
`define RCPP_HANG_RST      1'b0
`endif

// [core/rcpp_sync2.v]
// Two-stage synchroniser, one generate slice per bit
`timescale 1ns/1ps
module rcpp_sync2 #(
	parameter W = 1
) (
	input  wire         core_clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] async_i,
	input  wire [W-1:0] rst_val_i,
	output wire [W-1:0] sync_o
);
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			reg stage1;
			reg stage2;
			// Synchronous reset so the idle level can be a port value
			always @(posedge core_clk_i) begin
				if (rst_i) begin
					stage1 <= rst_val_i[g];
					stage2 <= rst_val_i[g];
				end else begin
					stage1 <= async_i[g];
					stage2 <= stage1;
				end
			end
			assign sync_o[g] = stage2;
		end
	endgenerate
endmodule

// [verification/rcpp_key_matrix.sv]
// Key matrix model behind the key-return and key-source pins
`timescale 1ns/1ps
module rcpp_key_matrix (
	input  wire [15:0] keys_i,
	input  wire [3:0]  src_oe_i,
	output wire [3:0]  ret_o
);
	genvar r;
	// Pull-up wins unless a closed key meets a source pulled low
	for (r = 0; r < 4; r = r + 1) begin : g_row
		assign ret_o[r] = ~|(keys_i[r*4+:4] & src_oe_i);
	end
endmodule

// [verification/rcpp_pin_port_monitor.sv]
// Assertion checker for the pin port logic
`timescale 1ns/1ps
module rcpp_pin_port_monitor (
	input wire core_clk_i, rst_i, key_source_we_i, hangup_alarm_n_oe_o,
	input wire carrier_i, carrier_en_i, ir_carrier_out_o, osc_run_o,
	input wire cpu_rst_o, standby_i, standby_release_o, wdt_overflow_i,
	input wire low_voltage_i,
	input wire [3:0] key_source_c_wr_i, key_source_port_c_oe_o, stack_ptr_i,
	input wire [3:0] key_return_port_a_i, key_return_port_a_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Two clean edges flush the synchroniser
	sequence s_run2;
		!rst_i ##1 !rst_i;
	endsequence
	AST_KSRC: assert property (key_source_we_i |=>
		key_source_port_c_oe_o == ~$past(key_source_c_wr_i))
		else $error("src oe");
	AST_SP: assert property (stack_ptr_i >= 4'h6 |=>
		hangup_alarm_n_oe_o) else $error("sp");
	AST_IR: assert property (1'b1 |=>
		ir_carrier_out_o == $past(carrier_i && carrier_en_i))
		else $error("ir");
	AST_OSC: assert property (disable iff (1'b0) rst_i |->
		cpu_rst_o && !osc_run_o) else $error("osc");
	AST_WAKE: assert property (standby_i &&
		!(&key_return_port_a_o) |=> standby_release_o) else $error("wake");
	AST_SYNC: assert property (s_run2 |=>
		key_return_port_a_o == $past(key_return_port_a_i, 2))
		else $error("sync");
	AST_WDT: assert property (wdt_overflow_i |=>
		hangup_alarm_n_oe_o [*4]) else $error("wdt");
	AST_LV: assert property (low_voltage_i |->
		hangup_alarm_n_oe_o) else $error("lv");
endmodule
bind rcpp_pin_port rcpp_pin_port_monitor u_mon (.*);

// [verification/tb_rcpp_pin_port.sv]
// Self-checking bench for the pin port logic
`timescale 1ns/1ps
module tb_rcpp_pin_port;
	logic core_clk_i, rst_i, key_source_we_i, bidir_cfg_we_i, bidir_data_we_i;
	logic standby_i, carrier_i, carrier_en_i, ext_int_i, test_mode_int_i;
	logic wdt_overflow_i, low_voltage_i;
	logic [3:0] wd, stack_ptr_i;
	logic [15:0] keys;
	wire [3:0] ret, soe, pe, poe, ppu, rpu;
	wire hang, ir;
	wire [3:0] kbo, sod, rd;
	wire rel, eint, crst, osc;
	int error_cnt = 0, tests_run = 0;
	rcpp_key_matrix km (.keys_i(keys), .src_oe_i(soe), .ret_o(ret));
	rcpp_pin_port uut (.*, .key_return_port_a_i(ret),
		.key_return_port_b_i(ret), .key_return_port_a_o(),
		.key_return_port_b_o(kbo), .key_return_pullup_o(rpu),
		.standby_release_o(rel), .key_source_c_wr_i(wd),
		.key_source_d_wr_i(wd), .key_source_port_c_oe_o(soe),
		.key_source_port_c_o(), .key_source_port_d_oe_o(sod),
		.key_source_port_d_o(), .bidir_dir_wr_i(wd),
		.bidir_pull_wr_i(~wd), .bidir_data_wr_i(wd),
		.bidir_port_e_i(pe), .bidir_port_e_o(pe), .bidir_port_e_oe_o(poe),
		.bidir_pullup_o(ppu), .bidir_port_e_rd_o(rd), .ext_int_o(eint),
		.ir_carrier_out_o(ir), .cpu_rst_o(crst), .osc_run_o(osc),
		.hangup_alarm_n_o(), .hangup_alarm_n_oe_o(hang));
	task chk(string n, logic [3:0] s, e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task stop_test;
		if (error_cnt == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tick(int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task t_rst;
		tick(3);
		chk("src", soe, 4'hF);
		chk("kb", kbo, 4'hF);
		chk("cpu", crst, 4'h1);
		chk("osc", osc, 4'h0);
		chk("dir", poe, 4'h0);
		chk("kpu", rpu, 4'hF);
		chk("ir", ir, 4'h0);
		chk("hang", hang, 4'h0);
		@(posedge core_clk_i) rst_i <= 0;
	endtask
	// Row 2 holds keys in a driven and an undriven column, so it reads low
	task t_keys;
		@(posedge core_clk_i) {key_source_we_i, wd, ext_int_i} <= 6'h2B;
		@(posedge core_clk_i) {key_source_we_i, standby_i, keys} <= 18'h10300;
		#1 chk("src", soe, 4'hA);
		chk("ret", ret, 4'hB);
		chk("srcd", sod, 4'hA);
		tick(3);
		chk("rel", rel, 4'h1);
		chk("int", eint, 4'h1);
		chk("kb", kbo, 4'hB);
		chk("ir", ir, 4'h1);
		chk("osc", osc, 4'h1);
	endtask
	task t_bidir;
		@(posedge core_clk_i) {bidir_cfg_we_i, wd, carrier_en_i} <= 6'h26;
		@(posedge core_clk_i) {bidir_cfg_we_i, bidir_data_we_i, wd} <= 6'h1A;
		#1 chk("oe", poe, 4'h3);
		chk("pu", ppu, 4'hC);
		chk("ir", ir, 4'h0);
		@(posedge core_clk_i) bidir_data_we_i <= 0;
		#1 chk("dat", pe & poe, 4'h2);
		chk("rd", rd, 4'hA);
	endtask
	task t_hang;
		@(posedge core_clk_i) stack_ptr_i <= 4'h6;
		@(posedge core_clk_i) {stack_ptr_i, test_mode_int_i} <= 5'h01;
		#1 chk("sp", hang, 4'h1);
		tick(3);
		chk("test", hang, 4'h1);
		@(posedge core_clk_i) {test_mode_int_i, wdt_overflow_i} <= 2'h1;
		@(posedge core_clk_i) {wdt_overflow_i, low_voltage_i} <= 2'h1;
		tick(4);
		@(posedge core_clk_i) {rst_i, low_voltage_i} <= 2'h3;
		tick(1);
		chk("lvr", hang, 4'h1);
		chk("cpu", crst, 4'h1);
		@(posedge core_clk_i) low_voltage_i <= 0;
		tick(1);
		chk("rst", hang, 4'h0);
	endtask
	initial begin
		core_clk_i = 0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	initial begin
		{rst_i, carrier_i, carrier_en_i, key_source_we_i} = 4'hE;
		{bidir_cfg_we_i, bidir_data_we_i, standby_i, ext_int_i} = 4'h0;
		{test_mode_int_i, wdt_overflow_i, low_voltage_i} = 3'h0;
		{wd, stack_ptr_i, keys} = 24'h0;
		t_rst;
		t_keys;
		t_bidir;
		t_hang;
		stop_test;
	end
	// Whole run is under 40 cycles
	initial begin
		#100000;
		error_cnt++;
		stop_test;
	end
endmodule
